// ===== dpb_param_bank.sv
// Drive parameter bank with password protection, special codes and input debounce
`include "dpb_cfg.svh"
module dpb_param_bank #(
	parameter int TICK_CYCLES = `DPB_TICK_CYCLES
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// APB slave
	input wire dpb_pkg::dpb_apb_req_t i_apb,
	output dpb_pkg::dpb_apb_rsp_t o_apb,
	// Nonvolatile password store
	input wire logic [15:0] i_nv_pwd,
	output logic [15:0] o_nv_pwd,
	output logic o_nv_pwd_we,
	// Special-function results
	output logic o_factory_req,
	output logic o_g4_unlock_one,
	output logic o_g4_unlock_block,
	output logic o_do_forced,
	output logic o_protect_locked,
	// Digital input one
	input wire logic i_di1_pin,
	output logic o_di1_active,
	output logic [7:0] o_di1_func,
	// Parameter values for the control loops
	output logic [15:0] o_speed_integral_gain,
	output logic [15:0] o_speed_feedforward_gain
);
	import dpb_pkg::*;

	logic [15:0] kvi_r, kvf_r, spf_r, drt_r, di1_r;
	logic [15:0] drt_act_r, di1_act_r;
	logic [15:0] pwd_cur_r, cand_r;
	logic protect_r, unlocked_r, boot_r;
	dpb_pw_state_t pw_state_r;
	logic [31:0] prdata_r;
	logic [15:0] wv;
	logic setup, wr_acc, hit_kvi, hit_kvf, hit_spf, hit_drt, hit_di1, hit_any;
	logic locked, range_bad, wr_err, sp_wr, sp_act;
	logic [15:0] rd_val;

	// Address decode and write qualification
	assign wv = i_apb.pwdata[15:0];
	assign setup = i_apb.psel && !i_apb.penable;
	assign wr_acc = i_apb.psel && i_apb.penable && i_apb.pwrite;
	assign hit_kvi = i_apb.paddr == 12'(`DPB_IDX_KVI * 4);
	assign hit_kvf = i_apb.paddr == 12'(`DPB_IDX_KVF * 4);
	assign hit_spf = i_apb.paddr == 12'(`DPB_IDX_SPF * 4);
	assign hit_drt = i_apb.paddr == 12'(`DPB_IDX_DRT * 4);
	assign hit_di1 = i_apb.paddr == 12'(`DPB_IDX_DI1 * 4);
	assign hit_any = hit_kvi || hit_kvf || hit_spf || hit_drt || hit_di1;
	assign locked = protect_r && !unlocked_r;
	assign range_bad = (hit_kvi && wv > `DPB_MAX_KVI) || (hit_kvf && wv > `DPB_MAX_KVF)
		|| (hit_drt && wv > `DPB_MAX_DRT) || (hit_di1 && wv > `DPB_MAX_DI1);
	assign wr_err = i_apb.pwrite && (!hit_any || range_bad || (locked && !hit_spf));
	assign sp_wr = wr_acc && hit_spf;
	assign sp_act = sp_wr && !locked;

	// Zero-wait answer; error flag on unmapped, out-of-range or refused access
	always_comb begin
		o_apb.prdata = prdata_r;
		o_apb.pready = 1'b1;
		o_apb.pslverr = i_apb.psel && i_apb.penable && (wr_err || (!i_apb.pwrite && !hit_any));
	end

	// Read mux
	always_comb begin
		rd_val = 16'h0000;
		if (hit_kvi) rd_val = kvi_r;
		if (hit_kvf) rd_val = kvf_r;
		if (hit_spf) rd_val = spf_r;
		if (hit_drt) rd_val = drt_r;
		if (hit_di1) rd_val = di1_r;
	end

	// Read data captured in the setup phase
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup && !i_apb.pwrite) begin
			prdata_r <= {16'h0000, rd_val};
		end
	end

	// Parameter registers; writes only when in range and not locked, except the special-function register, which is written while locked too
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			kvi_r <= `DPB_RST_KVI;
			kvf_r <= `DPB_RST_KVF;
			spf_r <= `DPB_RST_SPF;
			drt_r <= `DPB_RST_DRT;
			di1_r <= `DPB_RST_DI1;
		end else if (wr_acc && !wr_err) begin
			if (hit_kvi) kvi_r <= wv;
			if (hit_kvf) kvf_r <= wv;
			if (hit_spf) spf_r <= wv;
			if (hit_drt) drt_r <= wv;
			if (hit_di1) di1_r <= wv;
		end
	end

	// Boot flag marks the first cycle after reset release
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			boot_r <= 1'b1;
		end else begin
			boot_r <= 1'b0;
		end
	end

	// Protection armed only from the password found at power-up
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			protect_r <= 1'b0;
		end else if (boot_r) begin
			protect_r <= i_nv_pwd != 16'h0000;
		end
	end

	// Correct password entry lifts the lock until next reset
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			unlocked_r <= 1'b0;
		end else if (sp_wr && locked && wv == pwd_cur_r) begin
			unlocked_r <= 1'b1;
		end
	end

	// Password entry: set by double entry, clear by zero twice
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			pw_state_r <= DPB_PW_IDLE;
			cand_r <= 16'h0000;
			pwd_cur_r <= 16'h0000;
			o_nv_pwd <= 16'h0000;
			o_nv_pwd_we <= 1'b0;
		end else begin
			o_nv_pwd_we <= 1'b0;
			if (boot_r) begin
				pwd_cur_r <= i_nv_pwd;
				o_nv_pwd <= i_nv_pwd;
			end else if (sp_act) begin
				unique case (pw_state_r)
					DPB_PW_IDLE: begin
						if (wv >= `DPB_PWD_MIN) begin
							cand_r <= wv;
							pw_state_r <= DPB_PW_CONFIRM;
						end else if (wv == 16'h0000 && pwd_cur_r != 16'h0000) begin
							pw_state_r <= DPB_PW_CLEAR;
						end
					end
					DPB_PW_CONFIRM: begin
						if (wv == cand_r) begin
							pwd_cur_r <= wv;
							o_nv_pwd <= wv;
							o_nv_pwd_we <= 1'b1;
							pw_state_r <= DPB_PW_IDLE;
						end else if (wv >= `DPB_PWD_MIN) begin
							cand_r <= wv;
						end else begin
							pw_state_r <= DPB_PW_IDLE;
						end
					end
					DPB_PW_CLEAR: begin
						if (wv == 16'h0000) begin
							pwd_cur_r <= 16'h0000;
							o_nv_pwd <= 16'h0000;
							o_nv_pwd_we <= 1'b1;
						end
						pw_state_r <= DPB_PW_IDLE;
					end
					default: begin
						pw_state_r <= DPB_PW_IDLE;
					end
				endcase
			end
		end
	end

	// Special-function codes; other values do nothing here
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_factory_req <= 1'b0;
			o_g4_unlock_one <= 1'b0;
			o_g4_unlock_block <= 1'b0;
			o_do_forced <= 1'b0;
		end else if (sp_act) begin
			if (wv == `DPB_CODE_FACTORY) o_factory_req <= 1'b1;
			if (wv == `DPB_CODE_UNLOCK_ONE) o_g4_unlock_one <= 1'b1;
			if (wv == `DPB_CODE_UNLOCK_BLOCK) o_g4_unlock_block <= 1'b1;
			if (wv == `DPB_CODE_FORCE_ON) o_do_forced <= 1'b1;
			if (wv == `DPB_CODE_FORCE_OFF && o_do_forced) o_do_forced <= 1'b0;
		end
	end

	// Input configuration copied into use only right after restart
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			drt_act_r <= `DPB_RST_DRT;
			di1_act_r <= `DPB_RST_DI1;
		end else if (boot_r) begin
			drt_act_r <= drt_r;
			di1_act_r <= di1_r;
		end
	end

	// Pin synchroniser
	logic di_s1_r, di_s2_r, di_filt_r;
	logic [15:0] cyc_r;
	logic [4:0] ticks_r;
	logic tick_last;
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			di_s1_r <= 1'b0;
			di_s2_r <= 1'b0;
		end else begin
			di_s1_r <= i_di1_pin;
			di_s2_r <= di_s1_r;
		end
	end

	// Debounce: count 2 ms units of stable level, restart on bounce
	assign tick_last = cyc_r == 16'(TICK_CYCLES - 1);
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			cyc_r <= 16'h0000;
			ticks_r <= 5'h00;
			di_filt_r <= 1'b0;
		end else if (di_s2_r == di_filt_r) begin
			cyc_r <= 16'h0000;
			ticks_r <= 5'h00;
		end else if ({11'h000, ticks_r} >= drt_act_r) begin
			di_filt_r <= di_s2_r;
			cyc_r <= 16'h0000;
			ticks_r <= 5'h00;
		end else if (tick_last) begin
			cyc_r <= 16'h0000;
			ticks_r <= ticks_r + 5'h01;
		end else begin
			cyc_r <= cyc_r + 16'h0001;
		end
	end

	// Contact polarity and function code of input one
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_di1_active <= 1'b0;
			o_di1_func <= 8'h00;
		end else begin
			o_di1_active <= di1_act_r[`DPB_DI_CONTACT_BIT] ? di_filt_r : !di_filt_r;
			o_di1_func <= di1_act_r[`DPB_DI_FUNC_MSB:`DPB_DI_FUNC_LSB];
		end
	end

	assign o_speed_integral_gain = kvi_r;
	assign o_speed_feedforward_gain = kvf_r;
	assign o_protect_locked = locked;

	// Checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_sp_code(logic [15:0] c);
		sp_act && wv == c;
	endsequence
	sequence s_confirm_match;
		pw_state_r == DPB_PW_CONFIRM && sp_act && wv == cand_r;
	endsequence

	a_kvi_range: assert property (kvi_r <= `DPB_MAX_KVI) else $error("integral gain out of range");
	a_kvf_range: assert property (wr_acc && hit_kvf && wv > `DPB_MAX_KVF |=> $stable(kvf_r))
		else $error("feed-forward accepted out of range");
	a_factory_req: assert property (s_sp_code(`DPB_CODE_FACTORY) |=> o_factory_req)
		else $error("factory request not raised");
	a_unlock_one: assert property (s_sp_code(`DPB_CODE_UNLOCK_ONE) |=> o_g4_unlock_one)
		else $error("single unlock missing");
	a_unlock_block: assert property (s_sp_code(`DPB_CODE_UNLOCK_BLOCK) |=> o_g4_unlock_block)
		else $error("block unlock missing");
	a_force_on: assert property (s_sp_code(`DPB_CODE_FORCE_ON) |=> o_do_forced)
		else $error("forced mode not entered");
	a_force_off: assert property (o_do_forced ##0 s_sp_code(`DPB_CODE_FORCE_OFF) |=> !o_do_forced)
		else $error("forced mode not left");
	a_pwd_commit: assert property (s_confirm_match |=> o_nv_pwd_we && o_nv_pwd == $past(wv))
		else $error("password not stored on match");
	a_protect_boot: assert property (!boot_r |=> $stable(protect_r))
		else $error("protection changed after power-up");
	a_locked_reject: assert property (locked && wr_acc && hit_kvi |-> o_apb.pslverr ##1 $stable(kvi_r))
		else $error("write accepted while locked");
	a_pwd_clear: assert property (pw_state_r == DPB_PW_CLEAR ##0 s_sp_code(16'h0000) |=> o_nv_pwd_we && o_nv_pwd == 16'h0000)
		else $error("password not cleared");
	a_debounce_wait: assert property (!$stable(di_filt_r) |-> $past({11'h000, ticks_r}) >= $past(drt_act_r))
		else $error("input accepted before debounce time");
	a_config_boot: assert property (!boot_r |=> $stable(di1_act_r) && $stable(drt_act_r))
		else $error("input configuration changed without restart");
endmodule : dpb_param_bank

// ===== dpb_cfg.svh
// Constants for the drive parameter bank: offsets, field positions, resets and timing
//
// Overview of operation
// - Speed integral gain is 16 bits, accepts 0 to 1023, resets to 100.
// - Speed feed-forward gain is 16 bits, accepts 0 to 100, resets to 0.
// - Code 10 requests factory restore; it takes effect after a power cycle.
// - Code 20 unlocks writes to the single protected group-four parameter.
// - Code 22 unlocks writes to nine consecutive protected group-four parameters.
// - Code 406 forces the digital outputs into forced mode.
// - Code 400 while forced returns the digital outputs to normal mode.
// - A newly set password only protects after the next power-up.
// - While protected, parameter writes are refused until the right password is entered.
// - Correct password then zero twice clears the stored password.
// - Debounce time is the debounce setting times 2 ms, setting 0 to 20, reset 2.
// - Input setting holds function in low byte and contact selector in upper digit.
// - Selector 0 means normally closed input, 1 means normally open input.
// - Digital-input configuration is copied into use only at restart, which first reloads the reset values, so written changes never take effect.
`ifndef DPB_CFG_SVH
`define DPB_CFG_SVH
// Register indices; byte address is four times the index
`define DPB_IDX_KVI 12'h20c
`define DPB_IDX_KVF 12'h20e
`define DPB_IDX_SPF 12'h210
`define DPB_IDX_DRT 12'h212
`define DPB_IDX_DI1 12'h214
// Reset values
`define DPB_RST_KVI 16'h0064
`define DPB_RST_KVF 16'h0000
`define DPB_RST_SPF 16'h0000
`define DPB_RST_DRT 16'h0002
`define DPB_RST_DI1 16'h0101
// Accepted maxima
`define DPB_MAX_KVI 16'h03ff
`define DPB_MAX_KVF 16'h0064
`define DPB_MAX_DRT 16'h0014
`define DPB_MAX_DI1 16'h015f
// Special-function codes
`define DPB_CODE_FACTORY 16'h000a
`define DPB_CODE_UNLOCK_ONE 16'h0014
`define DPB_CODE_UNLOCK_BLOCK 16'h0016
`define DPB_CODE_FORCE_ON 16'h0196
`define DPB_CODE_FORCE_OFF 16'h0190
// Smallest five-digit password
`define DPB_PWD_MIN 16'h2710
// Input setting fields
`define DPB_DI_FUNC_MSB 7
`define DPB_DI_FUNC_LSB 0
`define DPB_DI_CONTACT_BIT 8
// Debounce unit timing
`define DPB_CLK_HZ 20000000
`define DPB_TICK_MS 2
`define DPB_TICK_CYCLES (`DPB_CLK_HZ / 1000 * `DPB_TICK_MS)
`endif

// ===== dpb_pkg.sv
// Types shared by the drive parameter bank
package dpb_pkg;
	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} dpb_apb_req_t;
	// APB answer to the master
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} dpb_apb_rsp_t;
	// Password entry sequencing
	typedef enum logic [1:0] {
		DPB_PW_IDLE = 2'b00,
		DPB_PW_CONFIRM = 2'b01,
		DPB_PW_CLEAR = 2'b10
	} dpb_pw_state_t;
endpackage : dpb_pkg

// ===== dpb_nv_store.sv
// Nonvolatile password store model facing the parameter bank
module dpb_nv_store (
	// Clock
	input wire logic i_clk,
	// Store port
	input wire logic i_we,
	input wire logic [15:0] i_data,
	output logic [15:0] o_data
);
	timeunit 1ns;
	timeprecision 1ns;
	// Content survives every reset, as flash would
	initial o_data = 16'h0000;
	always @(posedge i_clk) begin
		if (i_we === 1'b1) begin
			o_data <= i_data;
		end
	end
endmodule : dpb_nv_store

// ===== drive_param_bank_protect_debounce_test.sv
// Self-checking bench for the drive parameter bank
`include "dpb_cfg.svh"
module drive_param_bank_protect_debounce_test;
	timeunit 1ns;
	timeprecision 1ns;
	import dpb_pkg::*;
	localparam int TICK = 4;
	localparam logic [11:0] A_KVI = 12'(`DPB_IDX_KVI * 4);
	localparam logic [11:0] A_KVF = 12'(`DPB_IDX_KVF * 4);
	localparam logic [11:0] A_SPF = 12'(`DPB_IDX_SPF * 4);
	localparam logic [11:0] A_DRT = 12'(`DPB_IDX_DRT * 4);
	localparam logic [11:0] A_DI1 = 12'(`DPB_IDX_DI1 * 4);
	logic clk, rst, pin, nv_we, fac, u1, ub, forced, locked, active, hit;
	logic [15:0] nv_rd, nv_wd, speed_integral_gain, speed_feedforward_gain;
	logic [7:0] func;
	dpb_apb_req_t req;
	dpb_apb_rsp_t rsp;
	logic [33:0] q[$];
	logic [33:0] e;
	logic [15:0] codes[7] = '{16'd7, 16'd20, 16'd22, 16'd400, 16'd406, 16'd400, 16'd10};
	logic [3:0] flags[7] = '{4'h0, 4'h4, 4'h6, 4'h6, 4'h7, 4'h6, 4'he};
	int n_fail = 0;
	int tests_run = 0;
	logic [31:0] lfsr = 32'h06a36556;
	dpb_param_bank #(.TICK_CYCLES(TICK)) i_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_apb(req), .o_apb(rsp),
		.i_nv_pwd(nv_rd), .o_nv_pwd(nv_wd), .o_nv_pwd_we(nv_we), .o_factory_req(fac), .o_g4_unlock_one(u1),
		.o_g4_unlock_block(ub), .o_do_forced(forced), .o_protect_locked(locked), .i_di1_pin(pin),
		.o_di1_active(active), .o_di1_func(func), .o_speed_integral_gain(speed_integral_gain), .o_speed_feedforward_gain(speed_feedforward_gain));
	dpb_nv_store i_nv (.i_clk(clk), .i_we(nv_we), .i_data(nv_wd), .o_data(nv_rd));
	// Clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	function automatic logic [31:0] rnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : rnd
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test
	// One APB transfer; the expected answer is queued at setup
	task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d, input logic err);
		int n;
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {16'h0000, d}};
		q.push_back({~wr, err, 16'h0000, d});
		@(posedge clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		req <= '0;
	endtask : apb
	task automatic boot();
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : boot
	// Compares each completed transfer with the oldest note
	always @(posedge clk) begin
		if (active === 1'b1) hit <= 1'b1;
		if (req.psel && req.penable && rsp.pready === 1'b1) begin
			e = q.pop_front();
			chk("pslverr", {31'h0, rsp.pslverr}, {31'h0, e[32]});
			if (e[33]) chk("prdata", rsp.prdata, e[31:0]);
		end
	end
	// Hang guard
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		stop_test();
	end
	// Main sequence
	initial begin
		req = '0;
		pin = 1'b0;
		rst = 1'b1;
		hit = 1'b0;
		boot();
		apb(0, A_KVI, 16'h0064, 0);
		apb(0, A_KVF, 16'h0000, 0);
		apb(0, A_DRT, 16'h0002, 0);
		apb(0, A_DI1, 16'h0101, 0);
		@(negedge clk);
		chk("func", {24'h0, func}, 32'h1);
		apb(1, A_KVI, 16'h0400, 1);
		apb(1, A_KVF, 16'h0065, 1);
		apb(1, A_KVF, 16'h0064, 0);
		apb(1, A_DRT, 16'h0015, 1);
		apb(1, A_DI1, 16'h0160, 1);
		apb(0, 12'h004, 16'h0000, 1);
		lfsr = rnd(lfsr);
		apb(1, A_KVI, {6'h0, lfsr[9:0]}, 0);
		apb(0, A_KVI, {6'h0, lfsr[9:0]}, 0);
		@(negedge clk);
		chk("gains", {speed_integral_gain, speed_feedforward_gain}, {6'h0, lfsr[9:0], 16'h0064});
		// Special codes
		foreach (codes[k]) begin
			apb(1, A_SPF, codes[k], 0);
			@(negedge clk);
			chk("flags", {fac, u1, ub, forced}, flags[k]);
		end
		// Password set, armed at power-up, unlocked, cleared
		apb(1, A_SPF, 16'd12345, 0);
		apb(1, A_SPF, 16'd12345, 0);
		repeat (2) @(negedge clk);
		chk("nv", nv_rd, 12345);
		chk("lock", locked, 0);
		boot();
		chk("lock", locked, 1);
		apb(1, A_KVI, 16'h0005, 1);
		apb(1, A_SPF, 16'd11111, 0);
		@(negedge clk);
		chk("lock", locked, 1);
		apb(1, A_SPF, 16'd12345, 0);
		@(negedge clk);
		chk("lock", locked, 0);
		apb(1, A_KVI, 16'h0005, 0);
		apb(1, A_SPF, 16'h0000, 0);
		apb(1, A_SPF, 16'h0000, 0);
		repeat (2) @(negedge clk);
		chk("nv", nv_rd, 0);
		boot();
		chk("lock", locked, 0);
		// Debounce: glitches shorter than 2 x TICK are dropped
		hit = 1'b0;
		repeat (4) begin
			lfsr = rnd(lfsr);
			pin <= 1'b1;
			repeat (1 + lfsr[1:0]) @(posedge clk);
			pin <= 1'b0;
			repeat (12) @(posedge clk);
		end
		chk("glitch", hit, 0);
		pin <= 1'b1;
		repeat (8) @(posedge clk);
		@(negedge clk);
		chk("active", active, 0);
		repeat (20) @(posedge clk);
		chk("active", active, 1);
		// New input setting not in use before restart
		apb(1, A_DI1, 16'h0002, 0);
		apb(1, A_DRT, 16'h0000, 0);
		@(negedge clk);
		chk("func", {24'h0, func, 7'h0, active}, 32'h101);
		boot();
		repeat (30) @(posedge clk);
		@(negedge clk);
		// Restart brings the settings back to their reset values, so the defaults are in use again
		chk("func", {24'h0, func, 7'h0, active}, 32'h101);
		pin <= 1'b0;
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk("active", active, 1);
		stop_test();
	end
endmodule : drive_param_bank_protect_debounce_test
